// ==== radio_coexistence_handshake.sv ====
// Coexistence handshake with a neighbouring WLAN controller, AXI4-Lite slave.
// Assumes all inputs are synchronous to aclk and a 250 MHz clock.
`timescale 1ns/1ps
`include "coex_defs.svh"

// Overview of operation
// [R1] Two, three or four wire modes selectable.
// [R2] Fixed trio pins; four-wire adds overlap.
// [R3] Peer holds busy during its packets.
// [R4] Busy shown to software, which avoids sending.
// [R5] Two-wire: priority high during high-priority activity.
// [R6] Peer defers while priority is asserted.
// [R7] Request spans transaction, rises grant delay early.
// [R8] Status equals priority when request rises.
// [R9] After switch delay status shows direction.
// [R10] Direction updates reach status before packets.
// [R11] Overlap output set by software.
// [R12] Peer settles refusal within grant delay.
// [R13] Refusal sampled at grant delay stops transaction.
// [R14] Grant delay field resets to 0x31.
// [R15] Switch delay field resets to 0x13.
// [R16] Microsecond tick times delay plus one.
// [R17] Request and status drop at end or refusal.
module radio_coexistence_handshake
	import coex_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [`COEX_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`COEX_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic peer_busy_in,
	input wire logic coexist_refusal_in,
	output logic radio_priority_out,
	output logic radio_request_out,
	output logic radio_status_out,
	output logic radio_overlap_out
);

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] grant_q, switch_q;
	mode_e mode_q;
	logic hiprio_q, overlap_q, dir_q, dir_d, txn_prio_q;
	logic refused_q, busy_q, dir_phase_q, dir_phase_d;
	state_e state_q, state_d;
	logic [7:0] tick_cnt_q;
	logic [8:0] us_cnt_q;
	logic prio_out_q, req_out_q, stat_out_q, ovl_out_q;
	logic req_d, stat_d;

	// Bus decode. Address and data are taken together, in the same cycle.
	wire [13:0] aw_idx = awaddr[`COEX_ADDR_W-1:2];
	wire [13:0] ar_idx = araddr[`COEX_ADDR_W-1:2];
	wire wr_go = ce && awvalid && wvalid && !awready_q && !bvalid_q;
	wire wr_en = ce && awready_q && wstrb[0];
	wire rd_go = ce && arvalid && !arready_q && !rvalid_q;
	wire wr_grant = wr_en && aw_idx == `COEX_IDX_GRANT;
	wire wr_switch = wr_en && aw_idx == `COEX_IDX_SWITCH;
	wire wr_ctrl = wr_en && aw_idx == `COEX_IDX_CTRL;
	wire wr_cmd = wr_en && aw_idx == `COEX_IDX_CMD;
	wire wr_stat = wr_en && aw_idx == `COEX_IDX_STAT;
	wire aw_hit = aw_idx >= `COEX_IDX_GRANT && aw_idx <= `COEX_IDX_STAT;
	wire ar_hit = ar_idx >= `COEX_IDX_GRANT && ar_idx <= `COEX_IDX_STAT;
	wire [31:0] ctrl_rd = {28'h0, overlap_q, hiprio_q, mode_q};
	wire [31:0] cmd_rd = {29'h0, dir_q, txn_prio_q, 1'b0};
	wire [31:0] stat_rd = {26'h0, dir_phase_q, busy_q, state_q == ST_ACT,
		refused_q, stat_out_q, req_out_q};
	wire [31:0] rd_data =
		ar_idx == `COEX_IDX_GRANT ? {24'h0, grant_q} :
		ar_idx == `COEX_IDX_SWITCH ? {24'h0, switch_q} :
		ar_idx == `COEX_IDX_CTRL ? ctrl_rd :
		ar_idx == `COEX_IDX_CMD ? cmd_rd :
		ar_idx == `COEX_IDX_STAT ? stat_rd : 32'h0;

	// Transaction timing on a microsecond tick restarted at request rise.
	wire tick = tick_cnt_q == `COEX_TICK_LAST; // [R16]
	wire wire3 = mode_q == MODE_THREE || mode_q == MODE_FOUR; // [R2]
	wire start_w = wr_cmd && wdata[`COEX_CMD_START] && state_q == ST_IDLE
		&& wire3;
	wire end_w = (wr_cmd && wdata[`COEX_CMD_END]) || !wire3;
	wire sample_now = state_q == ST_REQ && tick
		&& us_cnt_q == {1'b0, grant_q}; // [R13]
	wire switch_now = state_q != ST_IDLE && tick
		&& us_cnt_q == {1'b0, switch_q}; // [R9]
	wire refuse_w = sample_now && coexist_refusal_in; // [R13]
	wire stop_w = refuse_w || (state_q != ST_IDLE && end_w);

	always_comb begin
		state_d = state_q;
		dir_d = (wr_cmd) ? wdata[`COEX_CMD_DIR] : dir_q; // [R10]
		dir_phase_d = dir_phase_q || switch_now;
		req_d = req_out_q;
		stat_d = dir_phase_d ? dir_d : txn_prio_q; // [R9]
		case (state_q)
			ST_IDLE: begin
				dir_phase_d = 1'b0;
				req_d = 1'b0;
				stat_d = 1'b0;
				if (start_w) begin
					state_d = ST_REQ;
					req_d = 1'b1; // [R7]
					stat_d = wdata[`COEX_CMD_PRIO]; // [R8]
				end
			end
			ST_REQ: begin
				if (sample_now && !coexist_refusal_in) begin
					state_d = ST_ACT;
				end
			end
			ST_ACT: begin
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (stop_w) begin
			state_d = ST_IDLE;
			req_d = 1'b0; // [R17]
			stat_d = 1'b0; // [R17]
			dir_phase_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `COEX_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `COEX_RESP_OKAY;
			rdata_q <= 32'h0;
		end else if (ce) begin
			awready_q <= wr_go;
			wready_q <= wr_go;
			arready_q <= rd_go;
			if (awready_q) begin
				bvalid_q <= 1'b1;
				bresp_q <= aw_hit ? `COEX_RESP_OKAY : `COEX_RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_data;
				rresp_q <= ar_hit ? `COEX_RESP_OKAY : `COEX_RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			grant_q <= `COEX_GRANT_RST; // [R14]
			switch_q <= `COEX_SWITCH_RST; // [R15]
			mode_q <= MODE_OFF;
			hiprio_q <= 1'b0;
			overlap_q <= 1'b0;
		end else if (ce) begin
			if (wr_grant) begin
				grant_q <= wdata[7:0]; // [R14]
			end
			if (wr_switch) begin
				switch_q <= wdata[7:0]; // [R15]
			end
			if (wr_ctrl) begin
				mode_q <= mode_e'(wdata[`COEX_CTRL_MODE]); // [R1]
				hiprio_q <= wdata[`COEX_CTRL_HIPRIO];
				overlap_q <= wdata[`COEX_CTRL_OVERLAP];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			dir_q <= 1'b0;
			txn_prio_q <= 1'b0;
			dir_phase_q <= 1'b0;
			refused_q <= 1'b0;
			busy_q <= 1'b0;
			tick_cnt_q <= 8'h0;
			us_cnt_q <= 9'h0;
		end else if (ce) begin
			state_q <= state_d;
			dir_q <= dir_d;
			dir_phase_q <= dir_phase_d;
			busy_q <= peer_busy_in; // [R4]
			if (start_w) begin
				txn_prio_q <= wdata[`COEX_CMD_PRIO];
			end
			// A refusal in the clearing cycle still sets the flag.
			if (refuse_w) begin
				refused_q <= 1'b1;
			end else if (wr_stat && wdata[`COEX_STAT_REFUSED]) begin
				refused_q <= 1'b0;
			end
			if (start_w || tick) begin
				tick_cnt_q <= 8'h0; // [R16]
			end else begin
				tick_cnt_q <= tick_cnt_q + 8'h1;
			end
			if (start_w) begin
				us_cnt_q <= 9'h0;
			end else if (tick && us_cnt_q != `COEX_US_MAX) begin
				us_cnt_q <= us_cnt_q + 9'h1; // [R16]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prio_out_q <= 1'b0;
			req_out_q <= 1'b0;
			stat_out_q <= 1'b0;
			ovl_out_q <= 1'b0;
		end else if (ce) begin
			prio_out_q <= mode_q == MODE_TWO && hiprio_q; // [R5]
			req_out_q <= req_d; // [R7]
			stat_out_q <= stat_d;
			ovl_out_q <= mode_q == MODE_FOUR && overlap_q; // [R11]
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign radio_priority_out = prio_out_q;
	assign radio_request_out = req_out_q;
	assign radio_status_out = stat_out_q;
	assign radio_overlap_out = ovl_out_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_refused_sample;
		ce && refuse_w;
	endsequence

	sequence s_line_dropped;
		!radio_request_out && !radio_status_out && refused_q;
	endsequence

	AST_REFUSE_DROPS: assert property ( // [R13]
		s_refused_sample |=> s_line_dropped)
		else $error("Refused transaction kept the request line.");

	AST_END_DROPS: assert property ( // [R17]
		(ce && state_q == ST_ACT && end_w) |=> !radio_request_out
			##1 (!radio_request_out || ce))
		else $error("Request not dropped at transaction end.");

	AST_STATUS_PRIO: assert property ( // [R8]
		$rose(radio_request_out) |-> radio_status_out == txn_prio_q)
		else $error("Status did not show priority at request rise.");

	AST_STATUS_DIR: assert property ( // [R9]
		(ce && dir_phase_q && state_q != ST_IDLE && !stop_w)
			|=> radio_status_out == dir_q)
		else $error("Status did not show direction after switch.");

	AST_SAMPLE_HELD: assert property ( // [R7]
		sample_now |-> radio_request_out
			&& us_cnt_q == {1'b0, grant_q})
		else $error("Grant sampled without request held.");

	AST_TWO_WIRE: assert property ( // [R5]
		(ce && mode_q == MODE_TWO && hiprio_q)
			|=> radio_priority_out && !radio_request_out)
		else $error("Priority not driven in two-wire mode.");

	AST_OVERLAP_MODE: assert property ( // [R11]
		(ce && mode_q != MODE_FOUR) |=> !radio_overlap_out)
		else $error("Overlap driven outside four-wire mode.");

	AST_RESET_DELAYS: assert property ( // [R14]
		$rose(aresetn) |-> grant_q == `COEX_GRANT_RST
			&& switch_q == `COEX_SWITCH_RST)
		else $error("Delay fields wrong after reset.");

	AST_TICK_RANGE: assert property ( // [R16]
		tick_cnt_q <= `COEX_TICK_LAST)
		else $error("Tick counter beyond one microsecond.");

endmodule : radio_coexistence_handshake

// ==== coex_defs.svh ====
// Constants for the radio coexistence handshake block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef COEX_DEFS_SVH
`define COEX_DEFS_SVH

// Register indices; the byte address is four times the index.
`define COEX_IDX_GRANT 14'hF12
`define COEX_IDX_SWITCH 14'hF13
`define COEX_IDX_CTRL 14'hF14
`define COEX_IDX_CMD 14'hF15
`define COEX_IDX_STAT 14'hF16

`define COEX_ADDR_W 16
`define COEX_GRANT_RST 8'h31
`define COEX_SWITCH_RST 8'h13

// Control register fields.
`define COEX_CTRL_MODE 1:0
`define COEX_CTRL_HIPRIO 2
`define COEX_CTRL_OVERLAP 3
// Command register fields.
`define COEX_CMD_START 0
`define COEX_CMD_PRIO 1
`define COEX_CMD_DIR 2
`define COEX_CMD_END 3
// Status register fields.
`define COEX_STAT_REFUSED 2

// One microsecond of the system clock.
`define COEX_TICK_US 1
`define COEX_CLK_MHZ 250
`define COEX_TICK_CYCLES (`COEX_TICK_US * `COEX_CLK_MHZ)
`define COEX_TICK_LAST 8'(`COEX_TICK_CYCLES - 1)
`define COEX_US_MAX 9'h1FF

`define COEX_RESP_OKAY 2'h0
`define COEX_RESP_SLVERR 2'h2

`endif

// ==== coex_pkg.sv ====
// Types shared by the radio coexistence handshake block.
// Assumes coex_defs.svh supplies the numeric constants.
package coex_pkg;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_TWO,
		MODE_THREE,
		MODE_FOUR
	} mode_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_ACT
	} state_e;

endpackage : coex_pkg

// ==== wlan_peer_model.sv ====
// Behavioural WLAN controller facing the coexistence block.
// Assumes the bench sets deny_en and traffic_en between transactions.
`timescale 1ns/1ps
module wlan_peer_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic radio_request_out,
	input wire logic radio_priority_out,
	input wire logic deny_en,
	input wire logic traffic_en,
	output logic peer_busy_in,
	output logic coexist_refusal_in
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			peer_busy_in <= 1'b0;
			coexist_refusal_in <= 1'b0;
		end else begin
			// Own packets are held back while the radio claims priority.
			peer_busy_in <= traffic_en & ~radio_priority_out;
			// The answer is settled before a request and held through it.
			if (!radio_request_out) begin
				coexist_refusal_in <= deny_en;
			end
		end
	end
endmodule : wlan_peer_model

// ==== radio_coexistence_handshake_test.sv ====
// Self-checking bench for the coexistence handshake block.
// Assumes coex_defs.svh and the WLAN peer model are compiled alongside.
`timescale 1ns/1ps
`include "coex_defs.svh"
module radio_coexistence_handshake_test;
	localparam logic [15:0] a_grant = {`COEX_IDX_GRANT, 2'b00};
	localparam logic [15:0] a_switch = {`COEX_IDX_SWITCH, 2'b00};
	localparam logic [15:0] a_ctrl = {`COEX_IDX_CTRL, 2'b00};
	localparam logic [15:0] a_cmd = {`COEX_IDX_CMD, 2'b00};
	localparam logic [15:0] a_stat = {`COEX_IDX_STAT, 2'b00};
	localparam logic [1:0] ok = `COEX_RESP_OKAY;
	localparam logic [1:0] err = `COEX_RESP_SLVERR;
	localparam int tick = `COEX_TICK_CYCLES;
	typedef struct {
		logic [15:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic [1:0] resp;
	} row_s;
	row_s rows [3] = '{'{a_grant, 32'h1FF, 32'hFF, ok},
		'{a_switch, 32'h100, 32'h0, ok}, '{a_stat + 16'h4, 32'h12, 32'h0, err}};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] awaddr = '0;
	logic [15:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic deny_en = 1'b0, traffic_en = 1'b0, req_q = 1'b0;
	logic ce = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic peer_busy_in, coexist_refusal_in;
	logic radio_priority_out, radio_request_out;
	logic radio_status_out, radio_overlap_out;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_errors = 0, checks_done = 0, cyc = 0, t_rise = 0;

	always #2 aclk = ~aclk;

	radio_coexistence_handshake dut_u (.aclk, .aresetn, .ce, .awaddr,
		.awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .peer_busy_in,
		.coexist_refusal_in, .radio_priority_out, .radio_request_out,
		.radio_status_out, .radio_overlap_out);
	wlan_peer_model peer_u (.aclk, .aresetn, .radio_request_out,
		.radio_priority_out, .deny_en, .traffic_en, .peer_busy_in,
		.coexist_refusal_in);

	// Cycle count, request rise time and the hang guard.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		req_q <= radio_request_out;
		if (radio_request_out === 1'b1 && req_q === 1'b0) t_rise = cyc;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end

	task automatic results;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Raised only after the address phase so that a previous call's
		// release of the response strobe never shares a time step with it.
		bready <= 1'b1;
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [31:0] mask,
		input logic [31:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, er});
		chk(rdata & mask, exp);
	endtask : rd

	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({radio_request_out, radio_status_out}), 32'h0);
		rd(a_grant, 32'hFFFFFFFF, 32'h31, ok);
		rd(a_switch, 32'hFFFFFFFF, 32'h13, ok);
	endtask : do_reset

	initial begin
		do_reset();
		for (int i = 0; i < 3; i++) begin
			wr(rows[i].a, rows[i].w, rows[i].resp);
			rd(rows[i].a, 32'hFFFFFFFF, rows[i].r, rows[i].resp);
		end
		// Two-wire mode: priority follows control, start is ignored.
		wr(a_ctrl, 32'h5, ok);
		traffic_en <= 1'b1;
		wr(a_cmd, 32'h1, ok);
		repeat (3) @(posedge aclk);
		chk(32'({radio_priority_out, radio_request_out}), 32'h2);
		wr(a_ctrl, 32'h2, ok);
		traffic_en <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(32'(radio_priority_out), 32'h0);
		// Granted high-priority receive, then a turn to transmit.
		wr(a_grant, 32'h1, ok);
		wr(a_switch, 32'h0, ok);
		wr(a_cmd, 32'h3, ok);
		chk(32'({radio_request_out, radio_status_out}), 32'h3);
		while (radio_status_out !== 1'b0) @(posedge aclk);
		chk(32'(cyc - t_rise), 32'(tick));
		repeat (2 * tick) @(posedge aclk);
		rd(a_stat, 32'h3F, 32'h29, ok);
		wr(a_cmd, 32'h4, ok);
		repeat (2) @(posedge aclk);
		chk(32'({radio_request_out, radio_status_out}), 32'h3);
		wr(a_cmd, 32'h8, ok);
		repeat (2) @(posedge aclk);
		chk(32'({radio_request_out, radio_status_out}), 32'h0);
		// Refused low-priority request in four-wire mode with overlap.
		deny_en <= 1'b1;
		traffic_en <= 1'b1;
		wr(a_ctrl, 32'hB, ok);
		wr(a_grant, 32'h0, ok);
		repeat (2) @(posedge aclk);
		chk(32'({radio_overlap_out, radio_priority_out}), 32'h2);
		wr(a_cmd, 32'h1, ok);
		chk(32'({radio_request_out, radio_status_out}), 32'h2);
		while (radio_request_out !== 1'b0) @(posedge aclk);
		chk(32'(cyc - t_rise), 32'(tick));
		rd(a_stat, 32'h17, 32'h14, ok);
		wr(a_stat, 32'h4, ok);
		rd(a_stat, 32'h4, 32'h0, ok);
		// A reset in mid-transaction restores the delay fields.
		// Clock enable held low freezes the switch delay of a new request.
		deny_en <= 1'b0;
		wr(a_cmd, 32'h3, ok);
		ce <= 1'b0;
		repeat (300) @(posedge aclk);
		ce <= 1'b1;
		chk(32'(radio_status_out), 32'h1);
		while (radio_status_out !== 1'b0) @(posedge aclk);
		chk(32'(cyc - t_rise), 32'(tick + 300));
		do_reset();
		results();
	end
endmodule : radio_coexistence_handshake_test
